// >>> nvmac_pkg.sv
// nvmac_pkg: shared constants and types for the nonvolatile access controller
// assumes a 32-bit classic wishbone register bus and a 100 MHz system clock
package nvmac_pkg;
  // register byte offsets
  localparam logic [7:0] ADDR_LOW_OFS = 8'h00;
  localparam logic [7:0] ADDR_HIGH_OFS = 8'h04;
  localparam logic [7:0] DATA_LOW_OFS = 8'h08;
  localparam logic [7:0] DATA_HIGH_OFS = 8'h0c;
  localparam logic [7:0] CONTROL_OFS = 8'h10;
  localparam logic [7:0] UNLOCK_OFS = 8'h14;
  localparam logic [7:0] FLAG2_OFS = 8'h18;
  // nvm_control bit positions
  localparam int CTL_FETCH_BIT = 0;
  localparam int CTL_START_BIT = 1;
  localparam int CTL_PERMIT_BIT = 2;
  localparam int CTL_ABORT_BIT = 3;
  localparam int CTL_CFG_BIT = 6;
  localparam int CTL_PGM_BIT = 7;
  // peripheral_flag_reg_2 bit position
  localparam int FLAG2_DONE_BIT = 4;
  // unlock patterns
  localparam logic [7:0] UNLOCK_FIRST = 8'h55;
  localparam logic [7:0] UNLOCK_SECOND = 8'haa;
  // widths
  localparam int DATA_BYTE_W = 8;
  localparam int PGM_DATA_W = 14;
  localparam int PGM_ADDR_W = 15;
  localparam int HIGH_ADDR_W = PGM_ADDR_W - DATA_BYTE_W;
  localparam int HIGH_DATA_W = PGM_DATA_W - DATA_BYTE_W;
  // timing
  localparam int CLK_MHZ = 100;
  localparam int ERASE_TIME_US = 2;
  localparam int PROG_TIME_US = 2;
  localparam int ERASE_CYCLES = ERASE_TIME_US * CLK_MHZ;
  localparam int PROG_CYCLES = PROG_TIME_US * CLK_MHZ;
  localparam int TIMER_W = 16;
  // self_program_lock encodings and protected region limits
  localparam logic [1:0] LOCK_NONE = 2'h3;
  localparam logic [1:0] LOCK_LOW = 2'h2;
  localparam logic [1:0] LOCK_HALF = 2'h1;
  localparam logic [PGM_ADDR_W-1:0] LOW_REGION_END = 15'h0200;
  localparam logic [PGM_ADDR_W-1:0] HALF_REGION_END = 15'h4000;

  typedef enum logic [1:0] {
    UNL_IDLE,
    UNL_FIRST,
    UNL_ARMED
  } nvmac_unlock_type;

  typedef enum logic [1:0] {
    OP_IDLE,
    OP_ERASE,
    OP_PROGRAM
  } nvmac_op_type;

  // request towards the two arrays
  typedef struct packed {
    logic rd;
    logic erase;
    logic prog;
    logic pgm_space;
    logic cfg_space;
    logic [PGM_ADDR_W-1:0] addr;
    logic [PGM_DATA_W-1:0] wdata;
  } nvmac_mem_req_type;
endpackage : nvmac_pkg

// >>> nvmac_op_timer.sv
// nvmac_op_timer: down-counter that times one erase or program phase
// assumes load is a one-cycle pulse and the count is at least one
`timescale 1ns/1ps
module nvmac_op_timer #(
  parameter int WIDTH = 16
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // control
  input wire logic load_i,
  input wire logic [WIDTH-1:0] count_i,
  // status
  output logic expired_o
);
  logic [WIDTH-1:0] count_q;
  logic running_q;

  // counts on its own, software cannot shorten the phase
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_q <= '0;
      running_q <= 1'b0;
    end else if (load_i) begin
      count_q <= count_i;
      running_q <= 1'b1;
    end else if (running_q) begin
      count_q <= count_q - 1'b1;
      if (count_q == WIDTH'(1)) begin
        running_q <= 1'b0;
      end
    end
  end

  // flops only: the caller reloads on expiry, so gating by load_i would loop
  assign expired_o = running_q && (count_q == WIDTH'(1));
endmodule : nvmac_op_timer

// >>> nvmac_ctrl.sv
// nvmac_ctrl: indirect access controller for data eeprom and program flash
// assumes arrays answer reads in the same cycle and a classic wishbone master
`timescale 1ns/1ps
module nvmac_ctrl #(
  parameter int ERASE_COUNT = nvmac_pkg::ERASE_CYCLES,
  parameter int PROG_COUNT = nvmac_pkg::PROG_CYCLES
) (
  // clock and resets
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic por_i,
  // wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // configuration settings
  input wire logic [1:0] self_program_lock_i,
  input wire logic code_lock_i,
  input wire logic data_readout_lock_i,
  // array port
  output nvmac_pkg::nvmac_mem_req_type mem_req_o,
  input wire logic [nvmac_pkg::PGM_DATA_W-1:0] mem_rdata_i,
  // external programmer access
  output logic ext_access_grant_o
);
  localparam int DW = nvmac_pkg::DATA_BYTE_W;
  localparam int HAW = nvmac_pkg::HIGH_ADDR_W;
  localparam int HDW = nvmac_pkg::HIGH_DATA_W;
  localparam int AW = nvmac_pkg::PGM_ADDR_W;
  localparam int TW = nvmac_pkg::TIMER_W;

  logic [DW-1:0] addr_low_q;
  logic [HAW-1:0] addr_high_q;
  logic [DW-1:0] data_low_q;
  logic [HDW-1:0] data_high_q;
  logic fetch_q;
  logic start_q;
  logic permit_q;
  logic abort_q;
  logic cfg_q;
  logic pgm_q;
  logic done_q;
  logic ack_q;
  logic [31:0] rdata_q;
  nvmac_pkg::nvmac_unlock_type unlock_q;
  nvmac_pkg::nvmac_op_type op_q;
  logic op_pgm_q;
  logic op_cfg_q;
  logic [AW-1:0] op_addr_q;
  logic [nvmac_pkg::PGM_DATA_W-1:0] op_data_q;
  logic timer_load;
  logic [TW-1:0] timer_count;
  logic timer_expired;
  logic bus_req;
  logic bus_wr;
  logic wr_addr_low;
  logic wr_addr_high;
  logic wr_data_low;
  logic wr_data_high;
  logic wr_control;
  logic wr_unlock;
  logic wr_flag2;
  logic start_req;
  logic start_ok;
  logic write_done;
  logic [AW-1:0] full_addr;
  logic region_locked;
  logic [DW-1:0] rd_mux;

  // bus decode, byte lane 0 carries every register
  assign bus_req = cyc_i && stb_i && !ack_q;
  assign bus_wr = bus_req && we_i && sel_i[0];
  assign wr_addr_low = bus_wr && (adr_i == nvmac_pkg::ADDR_LOW_OFS);
  assign wr_addr_high = bus_wr && (adr_i == nvmac_pkg::ADDR_HIGH_OFS);
  assign wr_data_low = bus_wr && (adr_i == nvmac_pkg::DATA_LOW_OFS);
  assign wr_data_high = bus_wr && (adr_i == nvmac_pkg::DATA_HIGH_OFS);
  assign wr_control = bus_wr && (adr_i == nvmac_pkg::CONTROL_OFS);
  assign wr_unlock = bus_wr && (adr_i == nvmac_pkg::UNLOCK_OFS);
  assign wr_flag2 = bus_wr && (adr_i == nvmac_pkg::FLAG2_OFS);

  // high byte only matters in program space
  assign full_addr = pgm_q ? {addr_high_q, addr_low_q} : {{HAW{1'b0}}, addr_low_q};

  // protected region test against the current address
  always_comb begin
    case (self_program_lock_i)
      nvmac_pkg::LOCK_NONE: region_locked = 1'b0;
      nvmac_pkg::LOCK_LOW: region_locked = full_addr < nvmac_pkg::LOW_REGION_END;
      nvmac_pkg::LOCK_HALF: region_locked = full_addr < nvmac_pkg::HALF_REGION_END;
      default: region_locked = 1'b1;
    endcase
  end

  assign start_req = wr_control && dat_i[nvmac_pkg::CTL_START_BIT] && !start_q;
  // armed detector and permit needed, plus a free region in program space
  assign start_ok = start_req && (unlock_q == nvmac_pkg::UNL_ARMED) && permit_q
    && !(pgm_q && region_locked);
  assign write_done = (op_q == nvmac_pkg::OP_PROGRAM) && timer_expired;

  // unlock detector: any write that is not the next step drops it
  always_ff @(posedge clk_i) begin
    if (rst_i || por_i) begin
      unlock_q <= nvmac_pkg::UNL_IDLE;
    end else if (bus_wr) begin
      case (unlock_q)
        nvmac_pkg::UNL_IDLE: begin
          unlock_q <= (wr_unlock && dat_i[DW-1:0] == nvmac_pkg::UNLOCK_FIRST) ?
            nvmac_pkg::UNL_FIRST : nvmac_pkg::UNL_IDLE;
        end
        nvmac_pkg::UNL_FIRST: begin
          unlock_q <= (wr_unlock && dat_i[DW-1:0] == nvmac_pkg::UNLOCK_SECOND) ?
            nvmac_pkg::UNL_ARMED : nvmac_pkg::UNL_IDLE;
        end
        default: unlock_q <= nvmac_pkg::UNL_IDLE;
      endcase
    end
  end

  // address registers
  always_ff @(posedge clk_i) begin
    if (rst_i || por_i) begin
      addr_low_q <= '0;
      addr_high_q <= '0;
    end else begin
      if (wr_addr_low) begin
        addr_low_q <= dat_i[DW-1:0];
      end
      if (wr_addr_high) begin
        addr_high_q <= dat_i[HAW-1:0];
      end
    end
  end

  // data registers: last read wins until software writes them
  always_ff @(posedge clk_i) begin
    if (rst_i || por_i) begin
      data_low_q <= '0;
      data_high_q <= '0;
    end else if (fetch_q) begin
      data_low_q <= mem_rdata_i[DW-1:0];
      data_high_q <= pgm_q ? mem_rdata_i[nvmac_pkg::PGM_DATA_W-1:DW] : '0;
    end else begin
      if (wr_data_low) begin
        data_low_q <= dat_i[DW-1:0];
      end
      if (wr_data_high) begin
        data_high_q <= dat_i[HDW-1:0];
      end
    end
  end

  // control bits; strobes cannot be cleared by software
  always_ff @(posedge clk_i) begin
    if (rst_i || por_i) begin
      fetch_q <= 1'b0;
      start_q <= 1'b0;
      permit_q <= 1'b0;
      cfg_q <= 1'b0;
      pgm_q <= 1'b0;
    end else begin
      if (fetch_q) begin
        fetch_q <= 1'b0;
      end else if (wr_control && dat_i[nvmac_pkg::CTL_FETCH_BIT]) begin
        fetch_q <= 1'b1;
      end
      if (write_done) begin
        start_q <= 1'b0;
      end else if (start_ok) begin
        start_q <= 1'b1;
      end
      if (wr_control) begin
        permit_q <= dat_i[nvmac_pkg::CTL_PERMIT_BIT];
        cfg_q <= dat_i[nvmac_pkg::CTL_CFG_BIT];
        pgm_q <= dat_i[nvmac_pkg::CTL_PGM_BIT];
      end
    end
  end

  // abort flag survives rst_i; only power-up or software clear it
  always_ff @(posedge clk_i) begin
    if (por_i) begin
      abort_q <= 1'b0;
    end else if (rst_i) begin
      abort_q <= abort_q || (op_q != nvmac_pkg::OP_IDLE);
    end else if (wr_control && !dat_i[nvmac_pkg::CTL_ABORT_BIT]) begin
      abort_q <= 1'b0;
    end
  end

  // done flag: hardware set beats a software clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i || por_i) begin
      done_q <= 1'b0;
    end else if (write_done) begin
      done_q <= 1'b1;
    end else if (wr_flag2 && !dat_i[nvmac_pkg::FLAG2_DONE_BIT]) begin
      done_q <= 1'b0;
    end
  end

  // write sequencer with captured operands
  always_ff @(posedge clk_i) begin
    if (rst_i || por_i) begin
      op_q <= nvmac_pkg::OP_IDLE;
      op_pgm_q <= 1'b0;
      op_cfg_q <= 1'b0;
      op_addr_q <= '0;
      op_data_q <= '0;
    end else begin
      case (op_q)
        nvmac_pkg::OP_IDLE: begin
          if (start_ok) begin
            op_pgm_q <= pgm_q;
            op_cfg_q <= cfg_q;
            op_addr_q <= full_addr;
            op_data_q <= {data_high_q, data_low_q};
            op_q <= pgm_q ? nvmac_pkg::OP_PROGRAM : nvmac_pkg::OP_ERASE;
          end
        end
        nvmac_pkg::OP_ERASE: begin
          if (timer_expired) begin
            op_q <= nvmac_pkg::OP_PROGRAM;
          end
        end
        nvmac_pkg::OP_PROGRAM: begin
          if (timer_expired) begin
            op_q <= nvmac_pkg::OP_IDLE;
          end
        end
        default: op_q <= nvmac_pkg::OP_IDLE;
      endcase
    end
  end

  // each phase reloads the timer
  assign timer_load = (start_ok && op_q == nvmac_pkg::OP_IDLE)
    || (op_q == nvmac_pkg::OP_ERASE && timer_expired);
  assign timer_count = (start_ok && op_q == nvmac_pkg::OP_IDLE && !pgm_q) ?
    TW'(ERASE_COUNT) : TW'(PROG_COUNT);

  nvmac_op_timer #(
    .WIDTH(TW)
  ) u_timer (
    .clk_i(clk_i),
    .rst_i(rst_i || por_i),
    .load_i(timer_load),
    .count_i(timer_count),
    .expired_o(timer_expired)
  );

  // array requests; arrays only seen through these strobes
  always_comb begin
    mem_req_o = '0;
    mem_req_o.rd = fetch_q;
    if (op_q == nvmac_pkg::OP_IDLE) begin
      mem_req_o.pgm_space = pgm_q;
      mem_req_o.cfg_space = cfg_q;
      mem_req_o.addr = full_addr;
    end else begin
      mem_req_o.erase = (op_q == nvmac_pkg::OP_ERASE);
      mem_req_o.prog = (op_q == nvmac_pkg::OP_PROGRAM);
      mem_req_o.pgm_space = op_pgm_q;
      mem_req_o.cfg_space = op_cfg_q;
      mem_req_o.addr = op_addr_q;
      mem_req_o.wdata = op_data_q;
    end
  end

  // processor keeps access under code lock; only the programmer is denied
  assign ext_access_grant_o = !(code_lock_i || data_readout_lock_i);

  // register read mux; unlock always reads zero
  always_comb begin
    rd_mux = '0;
    case (adr_i)
      nvmac_pkg::ADDR_LOW_OFS: rd_mux = addr_low_q;
      nvmac_pkg::ADDR_HIGH_OFS: rd_mux = DW'(addr_high_q);
      nvmac_pkg::DATA_LOW_OFS: rd_mux = data_low_q;
      nvmac_pkg::DATA_HIGH_OFS: rd_mux = DW'(data_high_q);
      nvmac_pkg::CONTROL_OFS: begin
        rd_mux[nvmac_pkg::CTL_FETCH_BIT] = fetch_q;
        rd_mux[nvmac_pkg::CTL_START_BIT] = start_q;
        rd_mux[nvmac_pkg::CTL_PERMIT_BIT] = permit_q;
        rd_mux[nvmac_pkg::CTL_ABORT_BIT] = abort_q;
        rd_mux[nvmac_pkg::CTL_CFG_BIT] = cfg_q;
        rd_mux[nvmac_pkg::CTL_PGM_BIT] = pgm_q;
      end
      nvmac_pkg::FLAG2_OFS: rd_mux[nvmac_pkg::FLAG2_DONE_BIT] = done_q;
      default: rd_mux = '0;
    endcase
  end

  // one registered ack per request, a cycle after it; unmapped addresses ack with zero
  always_ff @(posedge clk_i) begin
    if (rst_i || por_i) begin
      ack_q <= 1'b0;
      rdata_q <= '0;
    end else begin
      ack_q <= bus_req;
      if (bus_req && !we_i) begin
        rdata_q <= {24'h000000, rd_mux};
      end
    end
  end

  assign ack_o = ack_q;
  assign dat_o = rdata_q;
endmodule : nvmac_ctrl

// >>> nvmac_ctrl_props.sv
// nvmac_ctrl_props: port-level checks for the nvm access controller
// assumes bind onto nvmac_ctrl, one clock, synchronous active-high resets
`timescale 1ns/1ps
module nvmac_ctrl_props #(
  parameter int ERASE_COUNT = nvmac_pkg::ERASE_CYCLES,
  parameter int PROG_COUNT = nvmac_pkg::PROG_CYCLES
) (
  // clock and resets
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic por_i,
  // bus
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  // locks and array side
  input wire logic code_lock_i,
  input wire logic data_readout_lock_i,
  input nvmac_pkg::nvmac_mem_req_type mem_req_o,
  input wire logic ext_access_grant_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i || por_i);
  logic [15:0] e_q;
  logic [15:0] p_q;
  wire take = cyc_i && stb_i && !ack_o;
  wire busy = mem_req_o.erase || mem_req_o.prog;
  // phase lengths counted here since repetition counts must stay small
  always_ff @(posedge clk_i) begin
    e_q <= (rst_i || por_i || !mem_req_o.erase) ? 16'h0 : e_q + 16'h1;
  end
  always_ff @(posedge clk_i) begin
    p_q <= (rst_i || por_i || !mem_req_o.prog) ? 16'h0 : p_q + 16'h1;
  end
  sequence s_fetch;
    take && we_i && sel_i[0] && adr_i == nvmac_pkg::CONTROL_OFS && dat_i[0];
  endsequence
  sequence s_rd_pulse;
    mem_req_o.rd ##1 !mem_req_o.rd;
  endsequence
  a_ack_next: assert property (take |=> ack_o ##1 !ack_o)
    else $error("ack not one cycle after request");
  a_fetch_rd: assert property (s_fetch |=> s_rd_pulse)
    else $error("fetch did not give one read pulse");
  a_unlock_zero: assert property (take && !we_i && adr_i == nvmac_pkg::UNLOCK_OFS |=> dat_o == 32'h0)
    else $error("unlock register read not zero");
  a_grant_locks: assert property (ext_access_grant_o == !(code_lock_i || data_readout_lock_i))
    else $error("programmer grant wrong");
  a_erase_len: assert property ($fell(mem_req_o.erase) && !$past(rst_i) && !$past(por_i) |-> e_q == ERASE_COUNT)
    else $error("erase phase length wrong");
  a_erase_prog: assert property ($fell(mem_req_o.erase) && !$past(rst_i) && !$past(por_i) |-> mem_req_o.prog)
    else $error("erase not followed by program");
  a_prog_len: assert property ($fell(mem_req_o.prog) && !$past(rst_i) && !$past(por_i) |-> p_q == PROG_COUNT)
    else $error("program phase length wrong");
  a_erase_eeprom: assert property (mem_req_o.erase |-> !mem_req_o.pgm_space)
    else $error("erase on program space");
  a_hold_target: assert property (busy && $past(busy) |-> $stable(mem_req_o.addr) && $stable(mem_req_o.wdata))
    else $error("target changed during write");
endmodule : nvmac_ctrl_props

bind nvmac_ctrl nvmac_ctrl_props #(.ERASE_COUNT(ERASE_COUNT), .PROG_COUNT(PROG_COUNT)) i_props (
  .clk_i(clk_i), .rst_i(rst_i), .por_i(por_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
  .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .code_lock_i(code_lock_i),
  .data_readout_lock_i(data_readout_lock_i), .mem_req_o(mem_req_o), .ext_access_grant_o(ext_access_grant_o)
);

// >>> test_eeprom_flash_access_control.sv
// test_eeprom_flash_access_control: self-checking bench for nvmac_ctrl
// assumes nvmac_pkg and the bound checker are compiled first
`timescale 1ns/1ps
module test_eeprom_flash_access_control;
  localparam logic [7:0] A_LO = nvmac_pkg::ADDR_LOW_OFS;
  localparam logic [7:0] A_HI = nvmac_pkg::ADDR_HIGH_OFS;
  localparam logic [7:0] D_LO = nvmac_pkg::DATA_LOW_OFS;
  localparam logic [7:0] D_HI = nvmac_pkg::DATA_HIGH_OFS;
  localparam logic [7:0] CTL = nvmac_pkg::CONTROL_OFS;
  localparam logic [7:0] UNL = nvmac_pkg::UNLOCK_OFS;
  localparam logic [7:0] FLG = nvmac_pkg::FLAG2_OFS;
  logic clk_i = 1'h0, rst_i = 1'h1, por_i = 1'h1, cyc_i = 1'h0, stb_i = 1'h0, we_i = 1'h0, ack_o;
  logic [7:0] adr_i = 8'h0;
  logic [3:0] sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0, dat_o, rdat;
  logic code_lock_i = 1'h0, data_readout_lock_i = 1'h0, ext_access_grant_o, ok;
  logic [1:0] self_program_lock_i = 2'h3;
  nvmac_pkg::nvmac_mem_req_type mem_req_o;
  logic [13:0] mem_rdata_i, d;
  logic [14:0] a;
  int n_fail = 0, compares = 0, cyc_n = 0, seed = 76, i, k;
  // array stand-in: contents follow the address so reads are predictable
  assign mem_rdata_i = mem_req_o.addr[13:0] ^ 14'h1a5c;

  nvmac_ctrl #(.ERASE_COUNT(20), .PROG_COUNT(20)) i_dut (
    .clk_i(clk_i), .rst_i(rst_i), .por_i(por_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .self_program_lock_i(self_program_lock_i),
    .code_lock_i(code_lock_i), .data_readout_lock_i(data_readout_lock_i), .mem_req_o(mem_req_o),
    .mem_rdata_i(mem_rdata_i), .ext_access_grant_o(ext_access_grant_o)
  );

  initial begin
    forever #5 clk_i = ~clk_i;
  end

  function automatic logic allowed(input logic [1:0] l, input logic [14:0] ad);
    return l == nvmac_pkg::LOCK_NONE || (l == nvmac_pkg::LOCK_LOW && ad >= nvmac_pkg::LOW_REGION_END)
      || (l == nvmac_pkg::LOCK_HALF && ad >= nvmac_pkg::HALF_REGION_END);
  endfunction : allowed

  task automatic give_verdict;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict

  always @(posedge clk_i) begin
    cyc_n++;
    if (cyc_n == 20000) begin
      n_fail++;
      give_verdict();
    end
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk

  // classic cycle, entered just after a rising edge
  task automatic wb(input logic w, input logic [7:0] ad, input logic [7:0] dd);
    cyc_i <= 1'h1;
    stb_i <= 1'h1;
    we_i <= w;
    adr_i <= ad;
    dat_i <= {24'h0, dd};
    sel_i <= 4'hf;
    do @(posedge clk_i); while (ack_o !== 1'h1);
    rdat = dat_o;
    cyc_i <= 1'h0;
    stb_i <= 1'h0;
    @(posedge clk_i);
  endtask : wb

  task automatic rd(input logic [7:0] ad, input logic [31:0] e);
    wb(1'h0, ad, 8'h0);
    chk(rdat, e);
  endtask : rd

  task automatic start_wr(input logic pg, input logic [14:0] ad, input logic [13:0] dd);
    wb(1'h1, A_LO, ad[7:0]);
    wb(1'h1, A_HI, {1'h0, ad[14:8]});
    wb(1'h1, D_LO, dd[7:0]);
    wb(1'h1, D_HI, {2'h0, dd[13:8]});
    wb(1'h1, CTL, {pg, 7'h04});
    wb(1'h1, UNL, 8'h55);
    wb(1'h1, UNL, 8'haa);
    wb(1'h1, CTL, {pg, 7'h06});
  endtask : start_wr

  task automatic wait_phase;
    for (k = 0; k < 8 && !(mem_req_o.erase || mem_req_o.prog); k++) @(posedge clk_i);
  endtask : wait_phase

  task automatic wait_idle;
    do wb(1'h0, CTL, 8'h0); while (rdat[1] === 1'h1);
  endtask : wait_idle

  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'h0;
    por_i <= 1'h0;
    @(posedge clk_i);
    rd(CTL, 32'h0);
    rd(UNL, 32'h0);
    rd(8'h1c, 32'h0);
    $display("test reset done");
    for (i = 0; i < 8; i++) begin
      a = 15'($random(seed));
      ok = i[0];
      {code_lock_i, data_readout_lock_i, self_program_lock_i} <= 4'($random(seed));
      wb(1'h1, A_LO, a[7:0]);
      wb(1'h1, A_HI, {1'h0, a[14:8]});
      wb(1'h1, CTL, {ok, i[1], 6'h01});
      d = a[13:0] ^ 14'h1a5c;
      if (!ok) d[13:8] = 6'h0;
      rd(D_LO, {24'h0, d[7:0]});
      rd(D_HI, {26'h0, d[13:8]});
      rd(D_LO, {24'h0, d[7:0]});
      rd(CTL, {24'h0, ok, i[1], 6'h00});
      chk({31'h0, ext_access_grant_o}, {31'h0, !(code_lock_i || data_readout_lock_i)});
    end
    $display("test reads done");
    self_program_lock_i <= 2'h3;
    wb(1'h1, CTL, 8'h00);
    wb(1'h1, UNL, 8'h55);
    wb(1'h1, UNL, 8'haa);
    wb(1'h1, CTL, 8'h02);
    rd(CTL, 32'h0);
    wb(1'h1, CTL, 8'h04);
    wb(1'h1, UNL, 8'h55);
    wb(1'h1, A_LO, 8'h10);
    wb(1'h1, UNL, 8'haa);
    wb(1'h1, CTL, 8'h06);
    rd(CTL, 32'h04);
    wb(1'h1, UNL, 8'haa);
    wb(1'h1, UNL, 8'h55);
    wb(1'h1, CTL, 8'h06);
    rd(CTL, 32'h04);
    $display("test refusals done");
    a = 15'($random(seed));
    d = 14'($random(seed));
    start_wr(1'h0, a, d);
    wait_phase();
    chk({15'h0, mem_req_o.erase, mem_req_o.addr[7:0], mem_req_o.wdata[7:0]}, {15'h0, 1'h1, a[7:0], d[7:0]});
    wb(1'h1, D_LO, ~d[7:0]);
    wb(1'h1, CTL, 8'h00);
    rd(CTL, 32'h02);
    wait_idle();
    rd(D_LO, {24'h0, ~d[7:0]});
    rd(FLG, 32'h10);
    wb(1'h1, FLG, 8'h00);
    rd(FLG, 32'h0);
    $display("test eeprom write done");
    for (i = 0; i < 4; i++) begin
      self_program_lock_i <= i[1:0];
      a = (i == 2) ? 15'h01ff : 15'($random(seed));
      d = 14'($random(seed));
      ok = allowed(i[1:0], a);
      start_wr(1'h1, a, d);
      rd(CTL, {24'h0, ok ? 8'h86 : 8'h84});
      if (ok) begin
        wait_phase();
        chk({1'h0, mem_req_o.prog, mem_req_o.erase, a === mem_req_o.addr, d === mem_req_o.wdata}, 5'h0b);
        wait_idle();
      end
    end
    $display("test program locks done");
    self_program_lock_i <= 2'h3;
    start_wr(1'h1, 15'h4321, 14'h0abc);
    wait_phase();
    rst_i <= 1'h1;
    @(posedge clk_i);
    rst_i <= 1'h0;
    @(posedge clk_i);
    wb(1'h0, CTL, 8'h0);
    chk(rdat & 32'h8b, 32'h08);
    wb(1'h1, CTL, 8'h0c);
    rd(CTL, 32'h0c);
    por_i <= 1'h1;
    @(posedge clk_i);
    por_i <= 1'h0;
    @(posedge clk_i);
    rd(CTL, 32'h0);
    $display("test abort done");
    give_verdict();
  end
endmodule : test_eeprom_flash_access_control
